// ===== logic/sac_pkg.sv
////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the SAR converter control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
////////////////////////////////////////////////////////////////////////////
package sac_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_RES_HI = 8'h08;
    localparam logic [7:0] OFF_RES_LO = 8'h0C;
    localparam logic [7:0] OFF_FLAG = 8'h10;
    localparam logic [7:0] OFF_ENABLE = 8'h14;
    localparam logic [7:0] OFF_IRQCTL = 8'h18;

    // Field positions, converter_control_0
    localparam int CTRL0_ON = 0;
    localparam int CTRL0_GO = 1;
    localparam int CTRL0_CHAN_LO = 2;
    // Field positions, converter_control_1
    localparam int CTRL1_PREF = 0;
    localparam int CTRL1_CSEL_LO = 4;
    localparam int CTRL1_FM = 7;
    // Flag, enable and irq control fields
    localparam int FLAG_DONE = 0;
    localparam int ENABLE_IE = 0;
    localparam int IRQCTL_PERIPHERAL_IRQ_ENABLE = 0;
    localparam int IRQCTL_GIE = 1;

    // Reset values and the reserved channel code
    localparam logic [2:0] CHAN_RESET = 3'h0;
    localparam logic [2:0] CSEL_RESET = 3'h0;
    localparam logic [2:0] CHAN_RESERVED = 3'h7;

    // Result and sequencing
    localparam int RES_W = 10;
    localparam logic [3:0] MSB_IDX = 4'h9;
    localparam logic [1:0] HOLD_HALVES = 2'h3;
    localparam int PAD_W = 6;

    // Sequencer states, Gray coded along idle-hold-bits-finish
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_HOLD = 2'b01,
        SAC_BITS = 2'b11,
        SAC_FINISH = 2'b10
    } sac_state_t;

    // Signals toward the analog sample-and-hold and comparator
    typedef struct packed {
        logic [2:0] chan;
        logic ref_ext;
        logic hold;
        logic [RES_W-1:0] trial;
    } sac_ana_t;

    // Irq and wake requests toward the processor
    typedef struct packed {
        logic irq;
        logic wake;
        logic isr;
    } sac_cpu_t;

    // Clock select x11 picks the internal RC clock
    function automatic logic sac_is_rc(input logic [2:0] sel);
        return sel[1] & sel[0];
    endfunction : sac_is_rc

    // Half bit period in system clocks for the divided sources
    function automatic logic [5:0] sac_half_cycles(input logic [2:0] sel);
        unique case (sel)
            3'h0: return 6'h01;
            3'h4: return 6'h02;
            3'h1: return 6'h04;
            3'h5: return 6'h08;
            3'h2: return 6'h10;
            3'h6: return 6'h20;
            default: return 6'h01;
        endcase
    endfunction : sac_half_cycles

endpackage : sac_pkg

// ===== logic/sac_clkgen.sv
////////////////////////////////////////////////////////////////////////////
// Purpose: Half bit period tick generator for the converter sequencer
// Assumes: rc_clk_pin is asynchronous to pclk and much slower
// Notes: Each RC edge is one half bit period
////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module sac_clkgen #(
    parameter int CNT_W = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [2:0] clk_sel,
    input wire logic rc_clk_pin,
    output logic half_tick
);
    // Checked at elaboration so a bad width never builds
    if (CNT_W < 6) begin : g_cnt_w_check
        $error("sac_clkgen: CNT_W must be at least 6");
    end

    typedef struct packed {
        logic rc_s1;
        logic rc_s2;
        logic rc_s3;
        logic [CNT_W-1:0] cnt;
        logic tick;
    } sac_gen_t;

    sac_gen_t g_reg;
    sac_gen_t g_next;

    always_comb begin
        logic [CNT_W-1:0] limit;
        limit = CNT_W'(sac_pkg::sac_half_cycles(clk_sel));
        g_next = g_reg;
        g_next.rc_s1 = rc_clk_pin;
        g_next.rc_s2 = g_reg.rc_s1;
        g_next.rc_s3 = g_reg.rc_s2;
        g_next.tick = 1'b0;
        if (!run) begin
            g_next.cnt = '0;
        end else if (sac_pkg::sac_is_rc(clk_sel)) begin
            g_next.cnt = '0;
            g_next.tick = g_reg.rc_s2 ^ g_reg.rc_s3;
        end else if (g_reg.cnt == limit - CNT_W'(1)) begin
            // Counts system clocks, so the period follows pclk
            g_next.cnt = '0;
            g_next.tick = 1'b1;
        end else begin
            g_next.cnt = g_reg.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            g_reg <= '0;
        end else begin
            g_reg <= g_next;
        end
    end

    assign half_tick = g_reg.tick;

endmodule : sac_clkgen

// ===== logic/sac_top.sv
////////////////////////////////////////////////////////////////////////////
// Purpose: Control logic of a 10-bit successive-approximation converter
// Assumes: APB master on pclk; comparator answers the trial word
// Notes: Registers on APB, analog side through sac_ana_t
////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module sac_top #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_req,
    input wire logic rc_clk_pin,
    input wire logic cmp_above,
    output sac_pkg::sac_ana_t ana,
    output sac_pkg::sac_cpu_t cpu
);
    // Checked at elaboration so a bad width never builds
    if (ADDR_W < 5) begin : g_addr_w_check
        $error("sac_top: ADDR_W must be at least 5");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic on;
        logic go;
        logic [2:0] chan;
        logic [2:0] csel;
        logic pref;
        logic fm;
        logic [sac_pkg::RES_W-1:0] res;
        logic flag;
        logic ie;
        logic global_irq_enable;
        logic peripheral_irq_enable;
        sac_pkg::sac_state_t st;
        logic [1:0] hcnt;
        logic [3:0] idx;
        logic [sac_pkg::RES_W-1:0] sar;
        logic [sac_pkg::RES_W-1:0] trial;
        logic last;
        logic sleep_off;
        logic sleep_d;
        // One stage: the comparator has settled long before it is sampled
        logic cmp_s1;
        logic [31:0] rdata;
    } sac_regs_t;

    sac_regs_t s_reg;
    sac_regs_t s_next;
    logic half_tick;
    logic run;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic addr_mapped(input logic [7:0] a);
        return a == sac_pkg::OFF_CTRL0 || a == sac_pkg::OFF_CTRL1 ||
            a == sac_pkg::OFF_RES_HI || a == sac_pkg::OFF_RES_LO ||
            a == sac_pkg::OFF_FLAG || a == sac_pkg::OFF_ENABLE ||
            a == sac_pkg::OFF_IRQCTL;
    endfunction : addr_mapped

    // Undecided bits (index idx and below) copy the last decided bit
    function automatic logic [sac_pkg::RES_W-1:0] fill_partial(
        input logic [sac_pkg::RES_W-1:0] sar,
        input logic [3:0] idx,
        input logic last
    );
        logic [sac_pkg::RES_W-1:0] f;
        f = sar;
        for (int i = 0; i < sac_pkg::RES_W; i++) begin
            if (4'(i) <= idx) begin
                f[i] = last;
            end
        end
        return f;
    endfunction : fill_partial

    // Byte view of the result for the high or low register
    function automatic logic [7:0] result_byte(
        input logic [sac_pkg::RES_W-1:0] res,
        input logic fm,
        input logic high
    );
        logic [15:0] word;
        if (fm) begin
            word = {{sac_pkg::PAD_W{1'b0}}, res};
        end else begin
            word = {res, {sac_pkg::PAD_W{1'b0}}};
        end
        return high ? word[15:8] : word[7:0];
    endfunction : result_byte

    function automatic logic [31:0] read_word(
        input sac_regs_t r,
        input logic [7:0] a
    );
        logic [31:0] d;
        d = '0;
        unique case (a)
            sac_pkg::OFF_CTRL0: begin
                d[sac_pkg::CTRL0_ON] = r.on;
                d[sac_pkg::CTRL0_GO] = r.go;
                d[sac_pkg::CTRL0_CHAN_LO +: 3] = r.chan;
            end
            sac_pkg::OFF_CTRL1: begin
                d[sac_pkg::CTRL1_PREF] = r.pref;
                d[sac_pkg::CTRL1_CSEL_LO +: 3] = r.csel;
                d[sac_pkg::CTRL1_FM] = r.fm;
            end
            sac_pkg::OFF_RES_HI: d[7:0] = result_byte(r.res, r.fm, 1'b1);
            sac_pkg::OFF_RES_LO: d[7:0] = result_byte(r.res, r.fm, 1'b0);
            sac_pkg::OFF_FLAG: d[sac_pkg::FLAG_DONE] = r.flag;
            sac_pkg::OFF_ENABLE: d[sac_pkg::ENABLE_IE] = r.ie;
            sac_pkg::OFF_IRQCTL: begin
                d[sac_pkg::IRQCTL_PERIPHERAL_IRQ_ENABLE] = r.peripheral_irq_enable;
                d[sac_pkg::IRQCTL_GIE] = r.global_irq_enable;
            end
            default: d = '0;
        endcase
        return d;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////
    // Conversion clock
    assign run = s_reg.st != sac_pkg::SAC_IDLE;

    sac_clkgen #(
        .CNT_W(6)
    ) u_clkgen (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .clk_sel(s_reg.csel),
        .rc_clk_pin(rc_clk_pin),
        .half_tick(half_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [7:0] a;
        logic wr;
        logic setup_rd;
        logic done_set;
        logic rc;
        logic sleep_rise;
        logic [sac_pkg::RES_W-1:0] sar_new;
        a = 8'(paddr);
        wr = psel & penable & pwrite;
        setup_rd = psel & ~penable & ~pwrite;
        done_set = 1'b0;
        rc = sac_pkg::sac_is_rc(s_reg.csel);
        sleep_rise = sleep_req & ~s_reg.sleep_d;
        sar_new = s_reg.sar;
        s_next = s_reg;

        // Comparator follows the trial word set at the previous edge; a
        // second stage would leave the divide-by-2 decision one bit late
        s_next.cmp_s1 = cmp_above;
        s_next.sleep_d = sleep_req;

        // Sequencer
        unique case (s_reg.st)
            sac_pkg::SAC_IDLE: begin
                s_next.hcnt = '0;
            end
            sac_pkg::SAC_HOLD: begin
                if (half_tick) begin
                    if (s_reg.hcnt == sac_pkg::HOLD_HALVES - 2'h1) begin
                        s_next.st = sac_pkg::SAC_BITS;
                        s_next.hcnt = '0;
                        s_next.idx = sac_pkg::MSB_IDX;
                        s_next.trial = 10'h200;
                    end else begin
                        s_next.hcnt = s_reg.hcnt + 2'h1;
                    end
                end
            end
            sac_pkg::SAC_BITS: begin
                if (half_tick) begin
                    if (s_reg.hcnt == 2'h0) begin
                        s_next.hcnt = 2'h1;
                    end else begin
                        // One bit decided per bit period, MSB first
                        sar_new[s_reg.idx] = s_reg.cmp_s1;
                        s_next.sar = sar_new;
                        s_next.last = s_reg.cmp_s1;
                        s_next.hcnt = '0;
                        if (s_reg.idx == 4'h0) begin
                            s_next.st = sac_pkg::SAC_FINISH;
                        end else begin
                            s_next.idx = s_reg.idx - 4'h1;
                            s_next.trial = sar_new |
                                (10'h001 << (s_reg.idx - 4'h1));
                        end
                    end
                end
            end
            sac_pkg::SAC_FINISH: begin
                s_next.st = sac_pkg::SAC_IDLE;
                s_next.res = s_reg.sar;
                s_next.go = 1'b0;
                done_set = 1'b1;
                // In sleep with no interrupt the converter powers down
                if (sleep_req && !s_reg.ie) begin
                    s_next.sleep_off = 1'b1;
                end
            end
        endcase

        // Register writes, taken at the access edge
        if (wr) begin
            unique case (a)
                sac_pkg::OFF_CTRL0: begin
                    s_next.on = pwdata[sac_pkg::CTRL0_ON];
                    if (pwdata[sac_pkg::CTRL0_CHAN_LO +: 3] !=
                        sac_pkg::CHAN_RESERVED) begin
                        s_next.chan = pwdata[sac_pkg::CTRL0_CHAN_LO +: 3];
                    end
                    // Start needs the module already on before this write
                    if (pwdata[sac_pkg::CTRL0_GO] && s_reg.on &&
                        !s_reg.sleep_off && !run &&
                        (rc || !sleep_req)) begin
                        s_next.go = 1'b1;
                        s_next.st = sac_pkg::SAC_HOLD;
                        s_next.hcnt = '0;
                        s_next.idx = sac_pkg::MSB_IDX;
                        s_next.sar = '0;
                        s_next.trial = '0;
                        s_next.last = 1'b0;
                    end else if (!pwdata[sac_pkg::CTRL0_GO] && s_reg.go &&
                        s_reg.st != sac_pkg::SAC_FINISH) begin
                        s_next.go = 1'b0;
                        s_next.st = sac_pkg::SAC_IDLE;
                        s_next.res = fill_partial(s_reg.sar, s_reg.idx,
                            s_reg.last);
                    end
                    if (!pwdata[sac_pkg::CTRL0_ON] && run) begin
                        s_next.go = 1'b0;
                        s_next.st = sac_pkg::SAC_IDLE;
                    end
                end
                sac_pkg::OFF_CTRL1: begin
                    s_next.pref = pwdata[sac_pkg::CTRL1_PREF];
                    s_next.csel = pwdata[sac_pkg::CTRL1_CSEL_LO +: 3];
                    s_next.fm = pwdata[sac_pkg::CTRL1_FM];
                end
                sac_pkg::OFF_FLAG: begin
                    if (pwdata[sac_pkg::FLAG_DONE]) begin
                        s_next.flag = 1'b0;
                    end
                end
                sac_pkg::OFF_ENABLE: begin
                    s_next.ie = pwdata[sac_pkg::ENABLE_IE];
                end
                sac_pkg::OFF_IRQCTL: begin
                    s_next.peripheral_irq_enable = pwdata[sac_pkg::IRQCTL_PERIPHERAL_IRQ_ENABLE];
                    s_next.global_irq_enable = pwdata[sac_pkg::IRQCTL_GIE];
                end
                default: begin
                end
            endcase
        end

        // Sleep with a divided clock: the divided clock stops, so abort
        if (sleep_rise && !rc) begin
            s_next.go = 1'b0;
            s_next.st = sac_pkg::SAC_IDLE;
            s_next.sleep_off = 1'b1;
            done_set = 1'b0;
        end
        if (!sleep_req) begin
            s_next.sleep_off = 1'b0;
        end

        // Hardware set wins over a same-cycle software clear
        if (done_set) begin
            s_next.flag = 1'b1;
        end

        // Read data captured in the setup phase
        if (setup_rd) begin
            s_next.rdata = read_word(s_reg, a);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.chan <= sac_pkg::CHAN_RESET;
            s_reg.csel <= sac_pkg::CSEL_RESET;
            s_reg.st <= sac_pkg::SAC_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata = s_reg.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_mapped(8'(paddr));

    assign ana.chan = s_reg.chan;
    // Lower reference is hard wired to ground in the analog block
    assign ana.ref_ext = s_reg.pref;
    assign ana.hold = run;
    assign ana.trial = s_reg.trial;

    assign cpu.irq = s_reg.flag & s_reg.ie;
    assign cpu.wake = sleep_req & s_reg.flag & s_reg.ie;
    // The core runs the next instruction first, then takes this branch
    assign cpu.isr = s_reg.flag & s_reg.ie & s_reg.global_irq_enable & s_reg.peripheral_irq_enable;

endmodule : sac_top

// ===== dv/sac_assertions.sv
// Purpose: Port-level checks of the converter control block
// Assumes: Zero-wait APB slave, CTRL0 at byte offset 0x00
// Notes: Bound to sac_top from the bench top file
`timescale 1ns/100ps
module sac_assertions #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic sleep_req,
    input wire sac_pkg::sac_ana_t ana,
    input wire sac_pkg::sac_cpu_t cpu
);
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc;
    logic wr0;
    logic go_wr;
    assign acc = psel && penable;
    assign wr0 = acc && pwrite && paddr[7:0] == sac_pkg::OFF_CTRL0;
    assign go_wr = wr0 && pwdata[sac_pkg::CTRL0_GO];
    ////////////////////////////////////////////////////////////////////////
    chan_legal_a: assert property (ana.chan != 3'h7)
        else $error("reserved channel reached the mux");
    chan_write_a: assert property (wr0 && pwdata[4:2] != 3'h7 |=>
        ana.chan == $past(pwdata[4:2])) else $error("channel not taken");
    ref_write_a: assert property (acc && pwrite &&
        paddr[7:0] == sac_pkg::OFF_CTRL1 |=> ana.ref_ext == $past(pwdata[0]))
        else $error("reference select not taken");
    hold_cause_a: assert property ($rose(ana.hold) |-> $past(go_wr))
        else $error("hold rose without a start write");
    hold_zero_a: assert property ($rose(ana.hold) |-> ana.trial == 10'h000)
        else $error("trial word not cleared at start");
    hold_bound_a: assert property ($rose(ana.hold) |-> ##[1:1000] !ana.hold)
        else $error("conversion overran");
    wake_gate_a: assert property (cpu.wake |-> sleep_req && cpu.irq)
        else $error("wake without sleep and irq");
    isr_gate_a: assert property (cpu.isr |-> cpu.irq)
        else $error("isr without irq");
    irq_clear_a: assert property ($fell(cpu.irq) |-> $past(acc))
        else $error("irq fell without software access");
    irq_cause_a: assert property ($rose(cpu.irq) |->
        $fell(ana.hold) || $past(acc)) else $error("irq rose unprompted");
endmodule : sac_assertions

// ===== dv/sac_cmp_model.sv
// Purpose: Behavioural sample-and-hold and comparator
// Assumes: target is the held input as a 10-bit code
// Notes: slow answers one pclk late
`timescale 1ns/100ps
module sac_cmp_model (
    input wire logic pclk,
    input wire logic slow,
    input wire logic [9:0] target,
    input wire sac_pkg::sac_ana_t ana,
    output logic cmp_above
);
    logic late = 1'b0;
    logic tgl = 1'b0;
    logic now;
    assign now = target >= ana.trial;
    always @(posedge pclk) begin
        late <= now;
        tgl <= ~tgl;
    end
    // Toggles outside a conversion so a stale decision cannot look valid
    assign cmp_above = !ana.hold ? tgl : (slow ? late : now);
endmodule : sac_cmp_model

// ===== dv/sac_top_tb.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Zero-wait APB slave, RC clock unrelated to pclk
// Notes: Comparator model on the analog side
`timescale 1ns/100ps
module sac_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, sleep_req = 0, rc_clk_pin = 0;
    logic cmp_above, slow = 0;
    logic [9:0] target = 10'h000;
    sac_pkg::sac_ana_t ana;
    sac_pkg::sac_cpu_t cpu;
    int err_count = 0, compares = 0, cycles = 0, hold_cnt = 0;
    always #5 pclk = ~pclk;
    always #37 rc_clk_pin = ~rc_clk_pin;
    sac_top sac_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sleep_req, .rc_clk_pin,
        .cmp_above, .ana, .cpu);
    sac_cmp_model sac_cmp_model_i (.pclk, .slow, .target, .ana, .cmp_above);
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (ana.hold === 1'b1)
            hold_cnt <= hold_cnt + 1;
        if (cycles == 30000) begin
            err_count++;
            $display("mismatch at %0t: run timed out", $time);
            complete_run();
        end
    end
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check32
    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_idle();
        do apb(0, sac_pkg::OFF_CTRL0, 0); while (rd[1] === 1'b1);
    endtask : wait_idle
    task automatic set_in(input logic s, input logic sl);
        @(posedge pclk);
        sleep_req <= s;
        slow <= sl;
    endtask : set_in
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int a = 0; a <= 32'h1C; a += 4) begin
            apb(0, 8'(a), 0);
            check32(rd, 0);
        end
        check32({31'h0, er}, 1);
        apb(1, sac_pkg::OFF_RES_HI, 32'hFF);
        apb(0, sac_pkg::OFF_RES_HI, 0);
        check32(rd, 0);
        check32({14'h0, ana, cpu}, 0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_chan();
        for (int c = 0; c < 7; c++) begin
            apb(1, sac_pkg::OFF_CTRL0, 32'(c) << 2);
            @(negedge pclk);
            check32({29'h0, ana.chan}, 32'(c));
        end
        apb(1, sac_pkg::OFF_CTRL0, 32'h1C);
        @(negedge pclk);
        check32({29'h0, ana.chan}, 6);
        apb(1, sac_pkg::OFF_CTRL0, 32'h2);
        apb(0, sac_pkg::OFF_CTRL0, 0);
        check32({31'h0, rd[1] | ana.hold}, 0);
        $display("channel test done");
    endtask : t_chan
    task automatic t_conv(input logic [2:0] cs, input logic fm,
        input logic [9:0] tg);
        int half;
        half = 1 << (cs[1:0] * 2 + cs[2]);
        target <= tg;
        apb(1, sac_pkg::OFF_CTRL1, {24'h0, fm, cs, 3'h0, cs[0]});
        @(negedge pclk);
        check32({31'h0, ana.ref_ext}, {31'h0, cs[0]});
        apb(1, sac_pkg::OFF_FLAG, 1);
        apb(1, sac_pkg::OFF_CTRL0, 1);
        repeat (4) @(posedge pclk);
        hold_cnt = 0;
        apb(1, sac_pkg::OFF_CTRL0, 3);
        wait_idle();
        if (cs[1:0] != 2'b11)
            check32({31'h0, hold_cnt >= 23 * half
                && hold_cnt <= 23 * half + 5}, 1);
        apb(0, sac_pkg::OFF_RES_HI, 0);
        check32(rd, fm ? {30'h0, tg[9:8]} : {24'h0, tg[9:2]});
        apb(0, sac_pkg::OFF_RES_LO, 0);
        check32(rd, fm ? {24'h0, tg[7:0]} : {24'h0, tg[1:0], 6'h0});
        apb(0, sac_pkg::OFF_FLAG, 0);
        check32(rd, 1);
        $display("conversion test done, clock code %b", cs);
    endtask : t_conv
    task automatic t_irq();
        apb(1, sac_pkg::OFF_CTRL1, 32'h30);
        apb(1, sac_pkg::OFF_FLAG, 1);
        set_in(1'b1, 1'b0);
        apb(1, sac_pkg::OFF_CTRL0, 3);
        wait_idle();
        check32({29'h0, cpu}, 3'b000);
        apb(0, sac_pkg::OFF_FLAG, 0);
        check32(rd, 1);
        apb(1, sac_pkg::OFF_ENABLE, 1);
        @(negedge pclk);
        check32({29'h0, cpu}, 3'b110);
        apb(1, sac_pkg::OFF_IRQCTL, 3);
        @(negedge pclk);
        check32({29'h0, cpu}, 3'b111);
        set_in(1'b0, 1'b0);
        apb(1, sac_pkg::OFF_FLAG, 1);
        @(negedge pclk);
        check32({29'h0, cpu}, 3'b000);
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_abort();
        target <= 10'h3FF;
        set_in(1'b0, 1'b1);
        apb(1, sac_pkg::OFF_CTRL1, 32'hE0);
        apb(1, sac_pkg::OFF_CTRL0, 3);
        repeat (400) @(posedge pclk);
        apb(1, sac_pkg::OFF_CTRL0, 1);
        @(negedge pclk);
        check32({31'h0, ana.hold}, 0);
        apb(0, sac_pkg::OFF_RES_HI, 0);
        check32(rd, 3);
        apb(0, sac_pkg::OFF_RES_LO, 0);
        check32(rd, 32'hFF);
        apb(0, sac_pkg::OFF_FLAG, 0);
        check32(rd, 0);
        $display("abort test done");
    endtask : t_abort
    task automatic t_sleep();
        apb(1, sac_pkg::OFF_CTRL0, 3);
        repeat (100) @(posedge pclk);
        set_in(1'b1, 1'b0);
        repeat (3) @(posedge pclk);
        check32({31'h0, ana.hold}, 0);
        apb(0, sac_pkg::OFF_CTRL0, 0);
        check32(rd, 1);
        apb(1, sac_pkg::OFF_CTRL0, 3);
        apb(0, sac_pkg::OFF_CTRL0, 0);
        check32({rd[31:1], ana.hold}, 0);
        set_in(1'b0, 1'b0);
        $display("sleep test done");
    endtask : t_sleep
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_chan();
        for (int i = 0; i < 8; i++)
            t_conv(i[2:0], i[0], 10'h2A5 ^ 10'(i * 83));
        t_irq();
        t_abort();
        t_sleep();
        complete_run();
    end
endmodule : sac_top_tb
bind sac_top sac_assertions #(.ADDR_W(ADDR_W)) sac_assertions_i (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .sleep_req,
    .ana, .cpu);
